/* File: dma_ctrl_regs.svh */
`ifndef DMA_CTRL_REGS_SVH
`define DMA_CTRL_REGS_SVH

// ********************************************************************
// Control word field layout
// ********************************************************************
`define CTRL_MODE_MSB 2
`define CTRL_MODE_LSB 0
`define CTRL_NEXT_BURST_BIT 3
`define CTRL_COUNT_MSB 13
`define CTRL_COUNT_LSB 4
`define CTRL_RATE_MSB 17
`define CTRL_RATE_LSB 14

// ********************************************************************
// Field values and limits
// ********************************************************************
`define RATE_LAST_CODE 4'h9
`define MODE_INVALID 3'h0
`define MODE_BASIC 3'h1
`define MODE_AUTO_REQ 3'h2
`define MODE_PING_PONG 3'h3
`define MODE_MEM_SG_PRI 3'h4
`define MODE_MEM_SG_ALT 3'h5
`define MODE_PER_SG_PRI 3'h6
`define MODE_PER_SG_ALT 3'h7
`define COUNT_WIDTH 10
`define LEFT_WIDTH 11
`define LEFT_ONE 11'h001
`endif

/* File: dma_ctrl_pkg.sv */
`include "dma_ctrl_regs.svh"
package dma_ctrl_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {
      MODE_INVALID = `MODE_INVALID,
      MODE_BASIC = `MODE_BASIC,
      MODE_AUTO_REQ = `MODE_AUTO_REQ,
      MODE_PING_PONG = `MODE_PING_PONG,
      MODE_MEM_SG_PRI = `MODE_MEM_SG_PRI,
      MODE_MEM_SG_ALT = `MODE_MEM_SG_ALT,
      MODE_PER_SG_PRI = `MODE_PER_SG_PRI,
      MODE_PER_SG_ALT = `MODE_PER_SG_ALT
   } op_mode_t;

   // Gray codes along idle -> run -> idle, stopped one step off idle
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_STOPPED = 2'h2
   } chan_state_t;

   typedef logic [`LEFT_WIDTH-1:0] left_t;

   // Transfers per arbitration group, zero when arbitration is off
   function automatic left_t group_size(input logic [3:0] code);
      left_t size;
      size = '0;
      if (code <= `RATE_LAST_CODE) begin
         size = `LEFT_ONE << code;
      end
      return size;
   endfunction

endpackage

/* File: ctrl_word_decode.sv */
`timescale 1ns/100ps
`include "dma_ctrl_regs.svh"
module ctrl_word_decode (
   input wire logic [31:0] i_word,
   output dma_ctrl_pkg::op_mode_t o_mode,
   output dma_ctrl_pkg::left_t o_total,
   output dma_ctrl_pkg::left_t o_group,
   output logic o_next_burst,
   output logic o_alt_per_sg
);

   logic [`COUNT_WIDTH-1:0] count_field;
   logic [3:0] rate_field;

   // Field extraction, count is stored minus one
   always_comb begin
      count_field = i_word[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB];
      rate_field = i_word[`CTRL_RATE_MSB:`CTRL_RATE_LSB];
      o_total = {1'b0, count_field} + `LEFT_ONE;
      o_group = dma_ctrl_pkg::group_size(rate_field);
      o_next_burst = i_word[`CTRL_NEXT_BURST_BIT];
      // Mode codes map one to one onto the enum
      o_mode = dma_ctrl_pkg::op_mode_t'(
         i_word[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
      o_alt_per_sg = (o_mode == dma_ctrl_pkg::MODE_PER_SG_ALT);
   end

endmodule

/* File: dma_channel_control_decode.sv */
`timescale 1ns/100ps
`include "dma_ctrl_regs.svh"
module dma_channel_control_decode (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_load,
   input wire logic [31:0] i_ctrl_word,
   input wire logic i_xfer_done,
   input wire logic i_req_higher,
   input wire logic i_burst_set,
   input wire logic i_burst_clr,
   output logic o_xfer_req,
   output logic o_busy,
   output dma_ctrl_pkg::op_mode_t o_mode,
   output logic o_burst_only,
   output logic o_arb_point,
   output logic o_switch,
   output logic o_done,
   output logic o_invalid,
   output logic o_wb_valid,
   output logic [31:0] o_wb_word,
   output dma_ctrl_pkg::left_t o_left
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      dma_ctrl_pkg::chan_state_t st;
      dma_ctrl_pkg::op_mode_t mode;
      dma_ctrl_pkg::left_t left;
      dma_ctrl_pkg::left_t grp_cnt;
      dma_ctrl_pkg::left_t grp_size;
      logic next_burst;
      logic alt_per_sg;
      logic [31:0] word;
      logic burst_only;
      logic arb_point;
      logic switch_ch;
      logic done;
      logic invalid;
      logic wb_valid;
      logic [31:0] wb_word;
   } ctl_t;

   // Registered state and its next value
   ctl_t ctl_r;
   ctl_t ctl_nxt;

   // Decoder outputs, only meaningful in the load cycle
   dma_ctrl_pkg::op_mode_t dec_mode;
   dma_ctrl_pkg::left_t dec_total;
   dma_ctrl_pkg::left_t dec_group;
   logic dec_next_burst;
   logic dec_alt_per_sg;

   // Shared arithmetic on the held counts
   dma_ctrl_pkg::left_t left_dec;
   dma_ctrl_pkg::left_t cnt_inc;
   logic grp_end;

   // Requests from the sequencer on the burst-only flag
   logic hw_burst_set;
   logic hw_burst_clr;

   // ****************************************************************
   // Control word decode
   // ****************************************************************
   ctrl_word_decode u_decode (
      .i_word(i_ctrl_word),
      .o_mode(dec_mode),
      .o_total(dec_total),
      .o_group(dec_group),
      .o_next_burst(dec_next_burst),
      .o_alt_per_sg(dec_alt_per_sg)
   );

   // Rewrites the count field of the held word, minus-one coded
   function automatic logic [31:0] put_count(
      input logic [31:0] word,
      input dma_ctrl_pkg::left_t left
   );
      logic [31:0] w;
      dma_ctrl_pkg::left_t m1;
      w = word;
      m1 = left - `LEFT_ONE;
      w[`CTRL_COUNT_MSB:`CTRL_COUNT_LSB] = m1[`COUNT_WIDTH-1:0];
      return w;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      ctl_nxt = ctl_r;
      // Event outputs live for one cycle only
      ctl_nxt.arb_point = 1'b0;
      ctl_nxt.switch_ch = 1'b0;
      ctl_nxt.done = 1'b0;
      ctl_nxt.invalid = 1'b0;
      ctl_nxt.wb_valid = 1'b0;
      hw_burst_set = 1'b0;
      hw_burst_clr = 1'b0;
      left_dec = ctl_r.left - `LEFT_ONE;
      cnt_inc = ctl_r.grp_cnt + `LEFT_ONE;
      // A zero group size means arbitration is off for this run
      grp_end = (ctl_r.grp_size != '0) &&
                (cnt_inc == ctl_r.grp_size);

      case (ctl_r.st)
         dma_ctrl_pkg::ST_IDLE, dma_ctrl_pkg::ST_STOPPED: begin
            if (i_load) begin
               ctl_nxt.mode = dec_mode;
               ctl_nxt.word = i_ctrl_word;
               ctl_nxt.left = dec_total;
               ctl_nxt.grp_cnt = '0;
               ctl_nxt.grp_size = dec_group;
               ctl_nxt.next_burst = dec_next_burst;
               ctl_nxt.alt_per_sg = dec_alt_per_sg;
               if (dec_mode == dma_ctrl_pkg::MODE_INVALID) begin
                  // Invalid descriptor: no transfers, channel stops
                  ctl_nxt.st = dma_ctrl_pkg::ST_STOPPED;
                  ctl_nxt.invalid = 1'b1;
               end else begin
                  ctl_nxt.st = dma_ctrl_pkg::ST_RUN;
               end
            end
         end
         dma_ctrl_pkg::ST_RUN: begin
            if (i_xfer_done) begin
               ctl_nxt.left = left_dec;
               ctl_nxt.grp_cnt = cnt_inc;
               if (left_dec == '0) begin
                  // Last transfer: retire the descriptor
                  ctl_nxt.st = dma_ctrl_pkg::ST_IDLE;
                  ctl_nxt.done = 1'b1;
                  ctl_nxt.wb_valid = 1'b1;
                  ctl_nxt.wb_word = put_count(ctl_r.word, `LEFT_ONE);
                  ctl_nxt.wb_word[`CTRL_MODE_MSB:`CTRL_MODE_LSB] =
                     `MODE_INVALID;
                  // Flag untouched unless the bit asks for it
                  hw_burst_set = ctl_r.next_burst &&
                                 ctl_r.alt_per_sg;
               end else if (grp_end) begin
                  ctl_nxt.grp_cnt = '0;
                  ctl_nxt.arb_point = 1'b1;
                  // Short tail left: the next group cannot be full
                  hw_burst_clr = (left_dec < ctl_r.grp_size);
                  if (i_req_higher) begin
                     // Park with the remaining count saved for resume
                     ctl_nxt.st = dma_ctrl_pkg::ST_IDLE;
                     ctl_nxt.switch_ch = 1'b1;
                     ctl_nxt.wb_valid = 1'b1;
                     ctl_nxt.wb_word = put_count(ctl_r.word, left_dec);
                  end
               end
            end
         end
         default: begin
            ctl_nxt.st = dma_ctrl_pkg::ST_IDLE;
         end
      endcase

      // Burst-only flag: any set beats any clear in the same cycle
      if (hw_burst_set || i_burst_set) begin
         ctl_nxt.burst_only = 1'b1;
      end else if (hw_burst_clr || i_burst_clr) begin
         ctl_nxt.burst_only = 1'b0;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Reset clears every field, so no stray pulse follows release
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         ctl_r <= '{
            st: dma_ctrl_pkg::ST_IDLE,
            mode: dma_ctrl_pkg::MODE_INVALID,
            left: '0,
            grp_cnt: '0,
            grp_size: '0,
            next_burst: 1'b0,
            alt_per_sg: 1'b0,
            word: 32'h0000_0000,
            burst_only: 1'b0,
            arb_point: 1'b0,
            switch_ch: 1'b0,
            done: 1'b0,
            invalid: 1'b0,
            wb_valid: 1'b0,
            wb_word: 32'h0000_0000
         };
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Request stays up for the whole run, the bus answers per transfer
   assign o_xfer_req = (ctl_r.st == dma_ctrl_pkg::ST_RUN);
   assign o_busy = (ctl_r.st == dma_ctrl_pkg::ST_RUN);

   // Descriptor mode, held until the next load; burst-only flag held until set or cleared
   assign o_mode = ctl_r.mode;
   assign o_burst_only = ctl_r.burst_only;

   // Event pulses, each high for one cycle
   assign o_arb_point = ctl_r.arb_point;
   assign o_switch = ctl_r.switch_ch;
   assign o_done = ctl_r.done;
   assign o_invalid = ctl_r.invalid;
   assign o_wb_valid = ctl_r.wb_valid;

   // Write-back word stands until the next write-back
   assign o_wb_word = ctl_r.wb_word;
   assign o_left = ctl_r.left;

endmodule

/* File: dma_ctrl_chk_sva.sv */
`timescale 1ns/100ps
// *****************
// Checker
// *****************
module dma_ctrl_chk (
   input logic i_clock,
   input logic i_sys_rst,
   input logic i_load,
   input logic [31:0] i_ctrl_word,
   input logic i_xfer_done,
   input logic i_req_higher,
   input logic i_burst_set,
   input logic o_busy,
   input dma_ctrl_pkg::op_mode_t o_mode,
   input logic o_burst_only,
   input logic o_arb_point,
   input logic o_switch,
   input logic o_done,
   input logic o_invalid,
   input logic o_wb_valid,
   input logic [31:0] o_wb_word,
   input dma_ctrl_pkg::left_t o_left
);
   logic [3:0] rate_r;
   logic [2:0] m_r;
   logic nb_r;
   dma_ctrl_pkg::left_t tot_r;
   dma_ctrl_pkg::left_t grp;
   logic take;
   logic gend;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   // Shadow of the accepted descriptor
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rate_r <= 4'h0;
         m_r <= 3'h0;
         nb_r <= 1'b0;
         tot_r <= 11'h000;
      end else if (take) begin
         rate_r <= i_ctrl_word[17:14];
         m_r <= i_ctrl_word[2:0];
         nb_r <= i_ctrl_word[3];
         tot_r <= {1'b0, i_ctrl_word[13:4]} + 11'h001;
      end
   end
   // Group end: not the last transfer, count a multiple of the group
   assign take = i_load && !o_busy;
   assign grp = 11'h001 << rate_r;
   assign gend = o_busy && i_xfer_done && o_left > 11'h001 &&
      rate_r <= 4'h9 &&
      ((tot_r - o_left + 11'h001) & (grp - 11'h001)) == 11'h000;
   property p_inv;
      take && i_ctrl_word[2:0] == 3'h0 |=> o_invalid && !o_busy;
   endproperty
   a_inv: assert property (p_inv) else $error("invalid load");
   property p_load;
      take && i_ctrl_word[2:0] != 3'h0 |=> o_busy && o_mode ==
         $past(i_ctrl_word[2:0]) && o_left == tot_r;
   endproperty
   a_load: assert property (p_load) else $error("load");
   property p_grp;
      gend |=> o_arb_point;
   endproperty
   a_grp: assert property (p_grp) else $error("arb point");
   property p_norate;
      rate_r > 4'h9 |-> !o_arb_point;
   endproperty
   a_norate: assert property (p_norate) else $error("arb off");
   property p_sw;
      gend && i_req_higher |=> o_switch && !o_busy && o_wb_valid &&
         o_wb_word[13:4] == 10'($past(o_left) - 11'h002);
   endproperty
   a_sw: assert property (p_sw) else $error("switch");
   property p_done;
      o_busy && i_xfer_done && o_left == 11'h001 |=> o_done && o_wb_valid
         && o_wb_word[13:4] == 10'h000 && o_wb_word[2:0] == 3'h0;
   endproperty
   a_done: assert property (p_done) else $error("write back");
   property p_b5;
      $rose(o_burst_only) |-> $past(i_burst_set) ||
         (o_done && m_r == 3'h7 && nb_r);
   endproperty
   a_b5: assert property (p_b5) else $error("flag rose");
   property p_b6;
      o_busy && i_xfer_done && o_left == 11'h001 && m_r == 3'h7 && nb_r
         |=> o_burst_only;
   endproperty
   a_b6: assert property (p_b6) else $error("flag set");
   property p_b7;
      gend && (o_left - 11'h001) < grp && !i_burst_set |=> !o_burst_only;
   endproperty
   a_b7: assert property (p_b7) else $error("flag clear");
   c_sw: cover property (o_switch);
   c_inv: cover property (o_invalid);
   c_burst: cover property (o_done && o_burst_only);
endmodule
bind dma_channel_control_decode dma_ctrl_chk chk (.*);

/* File: xfer_source.sv */
`timescale 1ns/100ps
// *****************
// Far-side transfer source
// *****************
module xfer_source (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire logic i_slow,
   output logic o_done
);
   // Slow mode stalls the bus every other cycle
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_done <= 1'b0;
      end else begin
         o_done <= i_req && (!i_slow || !o_done);
      end
   end
endmodule

/* File: dma_channel_control_decode_test.sv */
`timescale 1ns/100ps
// *****************
// Testbench
// *****************
module dma_channel_control_decode_test;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_load = 1'b0;
   logic [31:0] i_ctrl_word = 32'h0;
   logic i_xfer_done;
   logic i_req_higher = 1'b0;
   logic i_burst_set = 1'b0;
   logic i_burst_clr = 1'b0;
   logic slow = 1'b0;
   logic o_xfer_req, o_busy, o_burst_only, o_arb_point, o_switch;
   logic o_done, o_invalid, o_wb_valid;
   logic [31:0] o_wb_word;
   dma_ctrl_pkg::op_mode_t o_mode;
   dma_ctrl_pkg::left_t o_left;
   int err_total = 0;
   int cmp_count = 0;
   dma_channel_control_decode dut (.i_clock, .i_sys_rst, .i_load,
      .i_ctrl_word, .i_xfer_done, .i_req_higher, .i_burst_set, .i_burst_clr,
      .o_xfer_req, .o_busy, .o_mode, .o_burst_only, .o_arb_point,
      .o_switch, .o_done, .o_invalid, .o_wb_valid, .o_wb_word, .o_left);
   xfer_source src (.i_clock, .i_sys_rst, .i_req(o_xfer_req),
      .i_slow(slow), .o_done(i_xfer_done));
   // 10 MHz clock
   initial begin
      forever #50 i_clock = ~i_clock;
   end
   task close_out;
      $display("errors %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
      end
   endtask
   // Inputs move 1 ns after the edge so sampling never races
   task tick;
      @(posedge i_clock);
      #1;
   endtask
   // Load a valid word, run to done or switch, count arb points
   task run(input logic [31:0] w, output int n);
      int k;
      n = 0;
      i_ctrl_word = w;
      i_load = 1'b1;
      tick;
      i_load = 1'b0;
      chk("left", 32'(w[13:4]) + 32'h1, 32'(o_left));
      for (k = 0; k < 3000 && !(o_done || o_switch); k++) begin
         tick;
         if (o_arb_point) n++;
      end
      if (!(o_done || o_switch)) begin
         err_total++;
         close_out;
      end
   endtask
   task t_invalid;
      i_ctrl_word = 32'h0000_0018;
      i_load = 1'b1;
      tick;
      i_load = 1'b0;
      chk("invalid", 32'h1, 32'(o_invalid));
      chk("busy", 32'h0, 32'(o_busy));
   endtask
   task t_modes;
      int n;
      for (int m = 1; m < 8; m++) begin
         run(32'(m), n);
         chk("mode", m, 32'(o_mode));
         chk("wb mode", 32'h0, 32'(o_wb_word[2:0]));
         chk("arb one", 32'h0, n);
      end
   endtask
   task t_rates;
      logic [3:0] codes [7] = '{4'h0, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA, 4'hF};
      int n;
      int want;
      for (int i = 0; i < 7; i++) begin
         slow = (i == 6);
         run({14'h0, codes[i], 10'h3FF, 4'h1}, n);
         want = (codes[i] <= 4'h9) ? (1024 >> codes[i]) - 1 : 0;
         chk("arb", want, n);
      end
      slow = 1'b0;
   endtask
   task t_switch;
      int n;
      i_req_higher = 1'b1;
      run({14'h0, 4'h1, 10'h005, 4'h1}, n);
      i_req_higher = 1'b0;
      chk("switch", 32'h1, 32'(o_switch));
      chk("wb count", 32'h3, 32'(o_wb_word[13:4]));
      chk("wb keep", 32'h1, 32'(o_wb_word[2:0]));
   endtask
   // Clear loses to set when both arrive together
   task t_burst;
      int n;
      run({14'h0, 4'hA, 10'h001, 4'hF}, n);
      tick;
      chk("flag set", 32'h1, 32'(o_burst_only));
      run({14'h0, 4'hA, 10'h001, 4'h7}, n);
      tick;
      chk("flag kept", 32'h1, 32'(o_burst_only));
      run({14'h0, 4'h1, 10'h002, 4'h1}, n);
      tick;
      chk("flag clear", 32'h0, 32'(o_burst_only));
      i_burst_set = 1'b1;
      i_burst_clr = 1'b1;
      tick;
      i_burst_set = 1'b0;
      i_burst_clr = 1'b0;
      tick;
      chk("set wins", 32'h1, 32'(o_burst_only));
   endtask
   initial begin
      repeat (2) tick;
      i_sys_rst = 1'b0;
      t_invalid;
      t_modes;
      t_rates;
      t_switch;
      t_burst;
      close_out;
   end
endmodule
